// ### lgs_pkg.sv
// Package for the logic cell input and gate 1 select block
package lgs_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [1:0] LGS_ADDR_DATA_THREE_FOUR_SELECT = 2'h0;
   localparam logic [1:0] LGS_ADDR_GATE_ONE_SELECT = 2'h1;
   localparam logic [7:0] LGS_SEL_IMPL_MASK = 8'h77;
   localparam int LGS_D4_SRC_LSB = 4;
   localparam int LGS_D3_SRC_LSB = 0;
   // Power-on value is undefined; zero chosen as the safe stand-in
   localparam logic [7:0] LGS_POWER_ON_VALUE = 8'h00;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lgs_req_t;

   typedef struct packed {
      logic gate_one_d4_true_en;
      logic gate_one_d4_inv_en;
      logic gate_one_d3_true_en;
      logic gate_one_d3_inv_en;
      logic gate_one_d2_true_en;
      logic gate_one_d2_inv_en;
      logic gate_one_d1_true_en;
      logic gate_one_d1_inv_en;
   } lgs_gate_sel_t;
endpackage : lgs_pkg

// ### lgs_select.sv
// Data 3/4 input selection and gate 1 select logic of a logic cell
`timescale 1ns/100ps
//Contract
// - Bits 6:4 pick bus line for data four
// - Bits 2:0 pick bus line for data three
// - Bits 7 and 3 read zero, ignore writes
// - Bits R/W; power-on reset only, others keep
// - Bits 7,6 gate true/inverted data four
// - Bits 5,4 gate true/inverted data three
// - Bits 3,2 gate true/inverted data two
// - Bits 1,0 gate true/inverted data one
module lgs_select import lgs_pkg::*; (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic power_on_reset,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Cell signals
   input wire logic [7:0] cell_input_bus,
   input wire logic data_signal_one,
   input wire logic data_signal_two,
   output logic data_signal_three,
   output logic data_signal_four,
   output logic gate_one_output
);
   // ****************************************
   // Registers
   // ****************************************
   lgs_req_t req;
   logic [7:0] data_three_four_select;
   lgs_gate_sel_t gate_one_select;
   logic [2:0] data_four_source;
   logic [2:0] data_three_source;
   logic wr_sel;
   logic wr_gate;
   logic [7:0] next_rdata;
   logic [7:0] gate_terms;
   logic next_gate;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign wr_sel = req.wr && req.addr == LGS_ADDR_DATA_THREE_FOUR_SELECT;
   assign wr_gate = req.wr && req.addr == LGS_ADDR_GATE_ONE_SELECT;

   // Only a power-on event clears settings; the plain reset keeps them
   always_ff @(posedge sys_clk) begin
      if (power_on_reset) begin
         data_three_four_select <= LGS_POWER_ON_VALUE;
         gate_one_select <= LGS_POWER_ON_VALUE;
      end else begin
         if (wr_sel) begin
            data_three_four_select <= req.wdata & LGS_SEL_IMPL_MASK;
         end
         if (wr_gate) begin
            gate_one_select <= req.wdata;
         end
      end
   end

   // ****************************************
   // Read back
   // ****************************************
   assign next_rdata = !req.rd ? 8'h00 :
      req.addr == LGS_ADDR_DATA_THREE_FOUR_SELECT ? data_three_four_select :
      req.addr == LGS_ADDR_GATE_ONE_SELECT ? gate_one_select : 8'h00;

   // ****************************************
   // Selection and gate 1
   // ****************************************
   assign data_four_source = data_three_four_select[LGS_D4_SRC_LSB +: 3];
   assign data_three_source = data_three_four_select[LGS_D3_SRC_LSB +: 3];
   assign gate_terms = {data_signal_four, ~data_signal_four,
                        data_signal_three, ~data_signal_three,
                        data_signal_two, ~data_signal_two,
                        data_signal_one, ~data_signal_one};
   // Registered data signals add one cycle before gating
   assign next_gate = |(gate_terms & gate_one_select);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         data_signal_four <= 1'b0;
         data_signal_three <= 1'b0;
         gate_one_output <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         data_signal_four <= cell_input_bus[data_four_source];
         data_signal_three <= cell_input_bus[data_three_source];
         gate_one_output <= next_gate;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_d4;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      ##1 !$past(reset) |-> data_signal_four == $past(cell_input_bus[data_three_four_select[LGS_D4_SRC_LSB +: 3]]);
   endproperty
   a_d4: assert property (p_d4) else $error("data four wrong");
   property p_d3;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      ##1 !$past(reset) |-> data_signal_three == $past(cell_input_bus[data_three_four_select[LGS_D3_SRC_LSB +: 3]]);
   endproperty
   a_d3: assert property (p_d3) else $error("data three wrong");
   property p_unimpl;
      @(posedge sys_clk) disable iff (reset)
      req.rd && req.addr == LGS_ADDR_DATA_THREE_FOUR_SELECT |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read one");
   property p_keep;
      @(posedge sys_clk) disable iff (power_on_reset)
      reset && !wr_gate |=> $stable(gate_one_select);
   endproperty
   a_keep: assert property (p_keep) else $error("reset altered settings");
   property p_wr;
      @(posedge sys_clk) disable iff (power_on_reset || reset)
      wr_gate ##1 req.rd && req.addr == LGS_ADDR_GATE_ONE_SELECT && !req.wr |=> reg_rdata == $past(req.wdata, 2);
   endproperty
   a_wr: assert property (p_wr) else $error("gate select readback wrong");
   property p_g4;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d4_true_en && data_signal_four |=> gate_one_output;
   endproperty
   a_g4: assert property (p_g4) else $error("data four true not gated");
   property p_g3;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d3_inv_en && !data_signal_three |=> gate_one_output;
   endproperty
   a_g3: assert property (p_g3) else $error("data three inverted not gated");
   property p_g2;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d2_true_en && data_signal_two |=> gate_one_output;
   endproperty
   a_g2: assert property (p_g2) else $error("data two true not gated");
   property p_g1;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d1_inv_en && !data_signal_one |=> gate_one_output;
   endproperty
   a_g1: assert property (p_g1) else $error("data one inverted not gated");
   property p_zero;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select == 8'h00 |=> !gate_one_output;
   endproperty
   a_zero: assert property (p_zero) else $error("gate high with nothing selected");
   property p_g4n;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d4_inv_en && !data_signal_four |=> gate_one_output;
   endproperty
   a_g4n: assert property (p_g4n) else $error("data four inverted not gated");
   property p_g3t;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d3_true_en && data_signal_three |=> gate_one_output;
   endproperty
   a_g3t: assert property (p_g3t) else $error("data three true not gated");
   property p_g2n;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d2_inv_en && !data_signal_two |=> gate_one_output;
   endproperty
   a_g2n: assert property (p_g2n) else $error("data two inverted not gated");
   property p_g1t;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      gate_one_select.gate_one_d1_true_en && data_signal_one |=> gate_one_output;
   endproperty
   a_g1t: assert property (p_g1t) else $error("data one true not gated");
   // Cleared bits must keep their term out of the gate
   property p_excl;
      @(posedge sys_clk) disable iff (reset || power_on_reset)
      !(gate_one_select.gate_one_d4_true_en && data_signal_four) &&
      !(gate_one_select.gate_one_d4_inv_en && !data_signal_four) &&
      !(gate_one_select.gate_one_d3_true_en && data_signal_three) &&
      !(gate_one_select.gate_one_d3_inv_en && !data_signal_three) &&
      !(gate_one_select.gate_one_d2_true_en && data_signal_two) &&
      !(gate_one_select.gate_one_d2_inv_en && !data_signal_two) &&
      !(gate_one_select.gate_one_d1_true_en && data_signal_one) &&
      !(gate_one_select.gate_one_d1_inv_en && !data_signal_one)
      |=> !gate_one_output;
   endproperty
   a_excl: assert property (p_excl) else $error("gate high with no enabled term true");

   // ****************************************
   // Register checks
   // ****************************************
   property p_keep_sel;
      @(posedge sys_clk) disable iff (power_on_reset)
      reset && !wr_sel |=> $stable(data_three_four_select);
   endproperty
   a_keep_sel: assert property (p_keep_sel) else $error("reset altered input selection");
   property p_hold_sel;
      @(posedge sys_clk) disable iff (power_on_reset)
      !wr_sel |=> $stable(data_three_four_select);
   endproperty
   a_hold_sel: assert property (p_hold_sel) else $error("input selection changed without write");
   property p_hold_gate;
      @(posedge sys_clk) disable iff (power_on_reset)
      !wr_gate |=> $stable(gate_one_select);
   endproperty
   a_hold_gate: assert property (p_hold_gate) else $error("gate select changed without write");
   property p_wr_sel_now;
      @(posedge sys_clk) disable iff (power_on_reset)
      wr_sel |=> data_three_four_select == ($past(req.wdata) & LGS_SEL_IMPL_MASK);
   endproperty
   a_wr_sel_now: assert property (p_wr_sel_now) else $error("input selection write lost");
   property p_wr_gate_now;
      @(posedge sys_clk) disable iff (power_on_reset)
      wr_gate |=> gate_one_select == $past(req.wdata);
   endproperty
   a_wr_gate_now: assert property (p_wr_gate_now) else $error("gate select write lost");
   property p_rd_sel;
      @(posedge sys_clk) disable iff (power_on_reset || reset)
      wr_sel ##1 req.rd && req.addr == LGS_ADDR_DATA_THREE_FOUR_SELECT && !req.wr
      |=> reg_rdata == ($past(req.wdata, 2) & LGS_SEL_IMPL_MASK);
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("input selection readback wrong");
   // Reserved bits must never be stored, whatever software writes
   property p_rsv;
      @(posedge sys_clk) disable iff (power_on_reset)
      (data_three_four_select & ~LGS_SEL_IMPL_MASK) == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved selection bit stored");
   property p_por;
      @(posedge sys_clk)
      power_on_reset |=> data_three_four_select == LGS_POWER_ON_VALUE && gate_one_select == LGS_POWER_ON_VALUE;
   endproperty
   a_por: assert property (p_por) else $error("power-on value not loaded");
endmodule : lgs_select

// ### lgs_select_bench.sv
// Self-checking bench for the data 3/4 and gate 1 select block
`timescale 1ns/100ps
module lgs_select_bench import lgs_pkg::*;;
   logic sys_clk = 1'b0, reset = 1'b1, por = 1'b1, wr = 1'b0, rd = 1'b0, d1 = 1'b0, d2 = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00, bus = 8'h00, rdata, sel = 8'h00, gls = 8'h00, e_rd = 8'h00;
   logic d3, d4, g, e_d3 = 1'b0, e_d4 = 1'b0, e_g = 1'b0;
   logic [31:0] rnd = 32'h192A;
   int n_fail = 0, n_compared = 0;

   always #25 sys_clk = ~sys_clk;

   lgs_select lgs_select_inst (.sys_clk(sys_clk), .reset(reset), .power_on_reset(por), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .cell_input_bus(bus),
      .data_signal_one(d1), .data_signal_two(d2), .data_signal_three(d3), .data_signal_four(d4),
      .gate_one_output(g));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   // ****************************************
   // Reference model
   // ****************************************
   // Sees pre-edge inputs, since the drivers update by non-blocking assignment
   always @(posedge sys_clk) begin
      if (por) begin
         sel <= LGS_POWER_ON_VALUE;
         gls <= LGS_POWER_ON_VALUE;
      end else if (wr && addr == LGS_ADDR_DATA_THREE_FOUR_SELECT) begin
         sel <= wdata & LGS_SEL_IMPL_MASK;
      end else if (wr && addr == LGS_ADDR_GATE_ONE_SELECT) begin
         gls <= wdata;
      end
      e_rd <= (reset || !rd) ? 8'h00 : addr == LGS_ADDR_DATA_THREE_FOUR_SELECT ? sel :
         addr == LGS_ADDR_GATE_ONE_SELECT ? gls : 8'h00;
      e_d3 <= !reset && bus[sel[2:0]];
      e_d4 <= !reset && bus[sel[6:4]];
      e_g <= !reset && |(gls & {e_d4, !e_d4, e_d3, !e_d3, d2, !d2, d1, !d1});
   end

   // Outputs are settled at the falling edge
   always @(negedge sys_clk) begin
      if (!por) begin
         check(rdata, e_rd);
         check({7'h00, d3}, {7'h00, e_d3});
         check({7'h00, d4}, {7'h00, e_d4});
         check({7'h00, g}, {7'h00, e_g});
      end
   end

   // ****************************************
   // Stimulus
   // ****************************************
   // Random strobes cover unmapped addresses, reserved bits and every select code
   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      por <= 1'b0;
      for (int i = 0; i < 2000; i++) begin
         @(posedge sys_clk);
         rnd = lfsr(rnd);
         wr <= rnd[1:0] == 2'h1;
         rd <= rnd[1:0] == 2'h2;
         addr <= rnd[3:2];
         wdata <= rnd[11:4];
         bus <= rnd[19:12];
         d1 <= rnd[20];
         d2 <= rnd[21];
         // Mid-run reset must keep the settings
         reset <= i >= 1000 && i < 1004;
      end
      @(posedge sys_clk);
      test_done();
   end
endmodule : lgs_select_bench
